// ==== scg_pkg.sv ====
package scg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] RUN_CLK_CFG_OFF = 12'h060;
  localparam logic [11:0] RUN_GATE_OFF    = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFF  = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFF   = 12'h120;
  localparam logic [11:0] INT_STAT_OFF    = 12'h130;
  localparam logic [11:0] INT_CLR_OFF     = 12'h134;
  localparam logic [11:0] INT_EN_OFF      = 12'h138;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_UNIT1_GATE_BIT      = 25;
  localparam int unsigned CTRL_UNIT0_GATE_BIT      = 24;
  localparam int unsigned ADC_BIT       = 16;
  localparam int unsigned SPD_LSB       = 8;
  localparam int unsigned HIB_BIT       = 6;
  localparam int unsigned WDT_BIT       = 3;
  localparam int unsigned ACG_BIT       = 27;
  localparam logic [31:0] GATE_RESET    = 32'h0000_0040;
  localparam logic [31:0] CLK_CFG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Gated units, index into the enable vector
  // ----------------------------------------------------------------
  localparam int unsigned NUM_UNITS = 5;
  localparam logic [2:0]  UNIT_WDT  = 3'h0;
  localparam logic [2:0]  UNIT_HIB  = 3'h1;
  localparam logic [2:0]  UNIT_ADC  = 3'h2;
  localparam logic [2:0]  UNIT_CTRL_UNIT0_GATE = 3'h3;
  localparam logic [2:0]  UNIT_CTRL_UNIT1_GATE = 3'h4;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP  = 2'b10
  } scg_mode_e;

  typedef struct packed {
    logic       ctrl_unit1_gate;
    logic       ctrl_unit0_gate;
    logic       adc_gate;
    logic [1:0] converter_sample_speed;
    logic       hibernation_gate;
    logic       watchdog_gate;
  } scg_gate_s;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } scg_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } scg_apb_rsp_s;

  function automatic scg_gate_s scg_unpack(input logic [31:0] w);
    scg_gate_s g;
    g.ctrl_unit1_gate        = w[CTRL_UNIT1_GATE_BIT];
    g.ctrl_unit0_gate        = w[CTRL_UNIT0_GATE_BIT];
    g.adc_gate               = w[ADC_BIT];
    g.converter_sample_speed = w[SPD_LSB+:2];
    g.hibernation_gate       = w[HIB_BIT];
    g.watchdog_gate          = w[WDT_BIT];
    return g;
  endfunction

  function automatic logic [31:0] scg_pack(input scg_gate_s g);
    logic [31:0] w;
    w                = 32'h0000_0000;
    w[CTRL_UNIT1_GATE_BIT]      = g.ctrl_unit1_gate;
    w[CTRL_UNIT0_GATE_BIT]      = g.ctrl_unit0_gate;
    w[ADC_BIT]       = g.adc_gate;
    w[SPD_LSB+:2]    = g.converter_sample_speed;
    w[HIB_BIT]       = g.hibernation_gate;
    w[WDT_BIT]       = g.watchdog_gate;
    return w;
  endfunction

  localparam scg_gate_s GATE_RST_S = scg_unpack(GATE_RESET);

endpackage

// ==== scg_top.sv ====
`timescale 1ns/100ps
// Functional notes
// - Each gate bit clocks or stops one unit
// - Access to unclocked unit answers bus fault
// - Gate register resets to 0x00000040
// - Sleep register; run and deep-sleep siblings
// - Sleep registers apply only with auto gating
// - Bit 25 gates second controller unit
// - Bit 24 gates first controller unit
// - Bit 16 gates converter module 0
// - Bits 9:8 select converter sample speed
// - Bit 6 gates hibernation, resets to one
// - Bit 3 gates watchdog, faults when unclocked
// - Reserved bits read zero, ignore writes
module scg_top
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire scg_pkg::scg_apb_req_s    apb_req,
  output scg_pkg::scg_apb_rsp_s         apb_rsp_ff,
  input  wire logic                     sleep_req,
  input  wire logic                     deepsleep_req,
  input  wire logic                     unit_acc_valid,
  input  wire logic [2:0]               unit_acc_idx,
  output logic                          unit_ok_ff,
  output logic                          unit_fault_ff,
  output logic [scg_pkg::NUM_UNITS-1:0] clk_en_ff,
  output logic [1:0]                    adc_speed_ff,
  output scg_pkg::scg_mode_e            mode_ff,
  output logic                          irq_ff
);
  import scg_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  scg_gate_s               run_gate_reg0_ff;
  scg_gate_s               sleep_gate_reg0_ff;
  scg_gate_s               deepsleep_gate_reg0_ff;
  logic                    auto_gating_select_ff;
  logic [NUM_UNITS-1:0]    int_stat_ff;
  logic [NUM_UNITS-1:0]    int_en_ff;
  scg_gate_s               nxt_run_gate_reg0;
  scg_gate_s               nxt_sleep_gate_reg0;
  scg_gate_s               nxt_deepsleep_gate_reg0;
  logic                    nxt_auto_gating_select;
  logic [NUM_UNITS-1:0]    nxt_int_stat;
  logic [NUM_UNITS-1:0]    nxt_int_en;
  logic [NUM_UNITS-1:0]    int_clr;
  logic [NUM_UNITS-1:0]    fault_evt;
  scg_apb_rsp_s            nxt_apb_rsp;
  logic                    setup_ph;
  logic                    wr_fire;
  logic                    addr_hit;
  logic [31:0]             rd_word;

  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign wr_fire  = apb_req.psel & apb_req.penable & apb_rsp_ff.pready & apb_req.pwrite & ~apb_rsp_ff.pslverr;

  // ----------------------------------------------------------------
  // APB decode and register next values
  // ----------------------------------------------------------------
  always_comb begin
    addr_hit = 1'b1;
    rd_word  = 32'h0000_0000;
    case (apb_req.paddr)
      RUN_GATE_OFF:    rd_word = scg_pack(run_gate_reg0_ff);
      SLEEP_GATE_OFF:  rd_word = scg_pack(sleep_gate_reg0_ff);
      DEEP_GATE_OFF:   rd_word = scg_pack(deepsleep_gate_reg0_ff);
      RUN_CLK_CFG_OFF: rd_word[ACG_BIT] = auto_gating_select_ff;
      INT_STAT_OFF:    rd_word[NUM_UNITS-1:0] = int_stat_ff;
      INT_CLR_OFF:     rd_word = 32'h0000_0000;
      INT_EN_OFF:      rd_word[NUM_UNITS-1:0] = int_en_ff;
      default:         addr_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_apb_rsp         = apb_rsp_ff;
    nxt_apb_rsp.pready  = setup_ph;
    if (setup_ph) begin
      nxt_apb_rsp.pslverr = ~addr_hit;
      nxt_apb_rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      nxt_apb_rsp.pslverr = 1'b0;
    end
  end

  always_comb begin
    nxt_run_gate_reg0       = run_gate_reg0_ff;
    nxt_sleep_gate_reg0     = sleep_gate_reg0_ff;
    nxt_deepsleep_gate_reg0 = deepsleep_gate_reg0_ff;
    nxt_auto_gating_select  = auto_gating_select_ff;
    nxt_int_en              = int_en_ff;
    int_clr                 = '0;
    if (wr_fire) begin
      // Only implemented bits are kept; reserved bits drop on write
      case (apb_req.paddr)
        RUN_GATE_OFF:    nxt_run_gate_reg0 = scg_unpack(apb_req.pwdata);
        SLEEP_GATE_OFF:  nxt_sleep_gate_reg0 = scg_unpack(apb_req.pwdata);
        DEEP_GATE_OFF:   nxt_deepsleep_gate_reg0 = scg_unpack(apb_req.pwdata);
        RUN_CLK_CFG_OFF: nxt_auto_gating_select = apb_req.pwdata[ACG_BIT];
        INT_CLR_OFF:     int_clr = apb_req.pwdata[NUM_UNITS-1:0];
        INT_EN_OFF:      nxt_int_en = apb_req.pwdata[NUM_UNITS-1:0];
        default:         int_clr = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp_ff             <= '0;
      run_gate_reg0_ff       <= GATE_RST_S;
      sleep_gate_reg0_ff     <= GATE_RST_S;
      deepsleep_gate_reg0_ff <= GATE_RST_S;
      auto_gating_select_ff  <= CLK_CFG_RESET[ACG_BIT];
      int_en_ff              <= '0;
    end else begin
      apb_rsp_ff             <= nxt_apb_rsp;
      run_gate_reg0_ff       <= nxt_run_gate_reg0;
      sleep_gate_reg0_ff     <= nxt_sleep_gate_reg0;
      deepsleep_gate_reg0_ff <= nxt_deepsleep_gate_reg0;
      auto_gating_select_ff  <= nxt_auto_gating_select;
      int_en_ff              <= nxt_int_en;
    end
  end

  // ----------------------------------------------------------------
  // Mode selection and effective gating
  // ----------------------------------------------------------------
  scg_mode_e               nxt_mode;
  scg_gate_s               eff_gate;
  logic [NUM_UNITS-1:0]    nxt_clk_en;
  logic [1:0]              nxt_adc_speed;

  always_comb begin
    nxt_mode = MODE_RUN;
    if (auto_gating_select_ff) begin
      if (deepsleep_req) begin
        nxt_mode = MODE_DEEP;
      end else if (sleep_req) begin
        nxt_mode = MODE_SLEEP;
      end
    end
  end

  always_comb begin
    case (mode_ff)
      MODE_RUN:   eff_gate = run_gate_reg0_ff;
      MODE_SLEEP: eff_gate = sleep_gate_reg0_ff;
      MODE_DEEP:  eff_gate = deepsleep_gate_reg0_ff;
      default:    eff_gate = run_gate_reg0_ff;
    endcase
    nxt_clk_en            = '0;
    nxt_clk_en[UNIT_WDT]  = eff_gate.watchdog_gate;
    nxt_clk_en[UNIT_HIB]  = eff_gate.hibernation_gate;
    nxt_clk_en[UNIT_ADC]  = eff_gate.adc_gate;
    nxt_clk_en[UNIT_CTRL_UNIT0_GATE] = eff_gate.ctrl_unit0_gate;
    nxt_clk_en[UNIT_CTRL_UNIT1_GATE] = eff_gate.ctrl_unit1_gate;
    nxt_adc_speed         = eff_gate.converter_sample_speed;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff      <= MODE_RUN;
      clk_en_ff    <= '0;
      adc_speed_ff <= 2'h0;
    end else begin
      mode_ff      <= nxt_mode;
      clk_en_ff    <= nxt_clk_en;
      adc_speed_ff <= nxt_adc_speed;
    end
  end

  // ----------------------------------------------------------------
  // Unit access check and fault interrupts
  // ----------------------------------------------------------------
  logic                    nxt_unit_ok;
  logic                    nxt_unit_fault;
  logic                    nxt_irq;
  logic                    acc_legal;

  // Out-of-range index faults like an unclocked target but sets no status bit
  assign acc_legal = unit_acc_idx < NUM_UNITS[2:0];

  always_comb begin
    nxt_unit_ok    = 1'b0;
    nxt_unit_fault = 1'b0;
    if (unit_acc_valid) begin
      if (acc_legal && clk_en_ff[unit_acc_idx]) begin
        nxt_unit_ok = 1'b1;
      end else begin
        nxt_unit_fault = 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++) begin : g_stat
      assign fault_evt[gi]    = unit_acc_valid & (unit_acc_idx == 3'(gi)) & ~clk_en_ff[gi];
      // Set beats clear so a fault in the clearing cycle survives
      assign nxt_int_stat[gi] = fault_evt[gi] | (int_stat_ff[gi] & ~int_clr[gi]);
    end
  endgenerate

  assign nxt_irq = |(nxt_int_stat & nxt_int_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_ok_ff    <= 1'b0;
      unit_fault_ff <= 1'b0;
      int_stat_ff   <= '0;
      irq_ff        <= 1'b0;
    end else begin
      unit_ok_ff    <= nxt_unit_ok;
      unit_fault_ff <= nxt_unit_fault;
      int_stat_ff   <= nxt_int_stat;
      irq_ff        <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sleep_write;
    wr_fire && apb_req.paddr == SLEEP_GATE_OFF;
  endsequence

  sequence s_sleep_held;
    auto_gating_select_ff && sleep_req && !deepsleep_req;
  endsequence

  sequence s_gated_access;
    unit_acc_valid && acc_legal && !clk_en_ff[unit_acc_idx];
  endsequence

  sequence s_in_sleep;
    mode_ff == MODE_SLEEP;
  endsequence

  gate_follows_mode_a: assert property (
    clk_en_ff[UNIT_WDT] == $past(eff_gate.watchdog_gate))
    else $error("watchdog enable does not follow selected register");

  fault_on_gated_a: assert property (
    unit_acc_valid && !clk_en_ff[unit_acc_idx] && acc_legal |=> unit_fault_ff && !unit_ok_ff)
    else $error("gated unit access not faulted");

  ok_on_clocked_a: assert property (
    unit_acc_valid && acc_legal && clk_en_ff[unit_acc_idx] |=> unit_ok_ff && !unit_fault_ff)
    else $error("clocked unit access faulted");

  reset_value_a: assert property (
    $rose(presetn) |-> scg_pack(sleep_gate_reg0_ff) == GATE_RESET)
    else $error("sleep gate register reset value wrong");

  sleep_write_a: assert property (
    s_sleep_write |=> scg_pack(sleep_gate_reg0_ff) == ($past(apb_req.pwdata) & scg_pack(scg_unpack(32'hFFFF_FFFF))))
    else $error("sleep gate register write not stored");

  sleep_applies_a: assert property (
    s_sleep_held [*2] |=> clk_en_ff[UNIT_HIB] == $past(sleep_gate_reg0_ff.hibernation_gate))
    else $error("sleep values not applied under auto gating");

  no_acg_run_a: assert property (
    !auto_gating_select_ff |=> mode_ff == MODE_RUN)
    else $error("sleep mode entered without auto gating");

  ctrl_unit1_gate_bit_a: assert property (
    mode_ff == MODE_SLEEP |=> clk_en_ff[UNIT_CTRL_UNIT1_GATE] == $past(sleep_gate_reg0_ff.ctrl_unit1_gate))
    else $error("bit 25 gate mismatch");

  ctrl_unit0_gate_bit_a: assert property (
    mode_ff == MODE_SLEEP |=> clk_en_ff[UNIT_CTRL_UNIT0_GATE] == $past(sleep_gate_reg0_ff.ctrl_unit0_gate))
    else $error("bit 24 gate mismatch");

  adc_bit_a: assert property (
    mode_ff == MODE_SLEEP |=> clk_en_ff[UNIT_ADC] == $past(sleep_gate_reg0_ff.adc_gate))
    else $error("bit 16 gate mismatch");

  speed_field_a: assert property (
    mode_ff == MODE_SLEEP |=> adc_speed_ff == $past(sleep_gate_reg0_ff.converter_sample_speed))
    else $error("sample speed field mismatch");

  wdt_fault_a: assert property (
    unit_acc_valid && unit_acc_idx == UNIT_WDT && !clk_en_ff[UNIT_WDT] |=> int_stat_ff[UNIT_WDT])
    else $error("watchdog fault not recorded");

  reserved_zero_a: assert property (
    apb_rsp_ff.pready && !apb_req.pwrite && apb_req.paddr == SLEEP_GATE_OFF
      |-> (apb_rsp_ff.prdata & 32'hFCFE_FCB7) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  hib_reset_a: assert property (
    $rose(presetn) |-> sleep_gate_reg0_ff.hibernation_gate)
    else $error("hibernation gate not set after reset");

  write_to_gate_a: assert property (
    s_sleep_write ##1 s_in_sleep |=> clk_en_ff[UNIT_ADC] == $past(apb_req.pwdata[ADC_BIT], 2))
    else $error("sleep register write not applied to enables");

  range_fault_a: assert property (
    unit_acc_valid && !acc_legal |=> unit_fault_ff && !unit_ok_ff)
    else $error("out of range unit access not faulted");

  fault_recorded_a: assert property (
    s_gated_access |=> unit_fault_ff && int_stat_ff != '0)
    else $error("gated access left no status");

  stat_hold_a: assert property (
    int_stat_ff[UNIT_ADC] && !int_clr[UNIT_ADC] |=> int_stat_ff[UNIT_ADC])
    else $error("fault status lost without clear");

  irq_level_a: assert property (
    irq_ff == |(int_stat_ff & int_en_ff))
    else $error("interrupt level disagrees with enabled status");

  deep_wins_a: assert property (
    auto_gating_select_ff && deepsleep_req |=> mode_ff == MODE_DEEP)
    else $error("deep sleep request not honoured");

  deep_applies_a: assert property (
    mode_ff == MODE_DEEP |=> clk_en_ff[UNIT_CTRL_UNIT1_GATE] == $past(deepsleep_gate_reg0_ff.ctrl_unit1_gate))
    else $error("deep sleep values not applied");

  run_applies_a: assert property (
    mode_ff == MODE_RUN |=> clk_en_ff[UNIT_HIB] == $past(run_gate_reg0_ff.hibernation_gate))
    else $error("run values not applied");

  hib_bit_a: assert property (
    s_in_sleep |=> clk_en_ff[UNIT_HIB] == $past(sleep_gate_reg0_ff.hibernation_gate))
    else $error("bit 6 gate mismatch");

  wdt_bit_a: assert property (
    s_in_sleep |=> clk_en_ff[UNIT_WDT] == $past(sleep_gate_reg0_ff.watchdog_gate))
    else $error("bit 3 gate mismatch");

  adc_fault_seen_a: assert property (
    unit_acc_valid && unit_acc_idx == UNIT_ADC && !clk_en_ff[UNIT_ADC] |=> int_stat_ff[UNIT_ADC] && unit_fault_ff)
    else $error("converter access while unclocked not faulted");

endmodule

// ==== sleep_clock_gate_reg0_tb.sv ====
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp); end end
module sleep_clock_gate_reg0_tb;
  import scg_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                  pclk;
  logic                  presetn;
  scg_apb_req_s          apb_req;
  scg_apb_rsp_s          apb_rsp;
  logic                  sleep_req;
  logic                  deepsleep_req;
  logic                  unit_acc_valid;
  logic [2:0]            unit_acc_idx;
  logic                  unit_ok;
  logic                  unit_fault;
  logic [NUM_UNITS-1:0]  clk_en;
  logic [1:0]            adc_speed;
  scg_mode_e             mode;
  logic                  irq;
  int                    n_mismatch;
  int                    num_checks;
  int                    cycles;
  logic [31:0]           rd;
  logic                  err;
  // Gate bit of each unit, by unit index
  int                    gate_pos [NUM_UNITS] = '{3, 6, 16, 24, 25};

  scg_top dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .apb_req        (apb_req),
    .apb_rsp_ff     (apb_rsp),
    .sleep_req      (sleep_req),
    .deepsleep_req  (deepsleep_req),
    .unit_acc_valid (unit_acc_valid),
    .unit_acc_idx   (unit_acc_idx),
    .unit_ok_ff     (unit_ok),
    .unit_fault_ff  (unit_fault),
    .clk_en_ff      (clk_en),
    .adc_speed_ff   (adc_speed),
    .mode_ff        (mode),
    .irq_ff         (irq)
  );

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Waits as long as the slave stalls; only the hang guard ends a stuck wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp, "read data")
    `CHK(err, exp_err, "slave error")
  endtask

  // One access aimed at a unit; answer looked at in its single cycle
  task automatic uacc(input logic [2:0] idx, input logic exp_fault, input logic exp_irq);
    @(posedge pclk);
    unit_acc_valid <= 1'b1;
    unit_acc_idx <= idx;
    @(posedge pclk);
    unit_acc_valid <= 1'b0;
    #1;
    `CHK(unit_fault, exp_fault, "unit fault")
    `CHK(unit_ok, ~exp_fault, "unit ok")
    `CHK(irq, exp_irq, "interrupt")
  endtask

  // Gating follows a write or mode change two edges later; margin added
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    sleep_req = 1'b0;
    deepsleep_req = 1'b0;
    unit_acc_valid = 1'b0;
    unit_acc_idx = 3'h0;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    `CHK(clk_en, 5'b00010, "clock enables after reset")
    `CHK(mode, MODE_RUN, "mode after reset")
    rd_chk(SLEEP_GATE_OFF, 32'h0000_0040, 1'b0);
    rd_chk(RUN_GATE_OFF, 32'h0000_0040, 1'b0);
    rd_chk(DEEP_GATE_OFF, 32'h0000_0040, 1'b0);
    $display("test reset done");

    wr_reg(SLEEP_GATE_OFF, 32'hFFFF_FFFF);
    rd_chk(SLEEP_GATE_OFF, 32'h0301_0348, 1'b0);
    wr_reg(SLEEP_GATE_OFF, 32'h0000_0000);
    rd_chk(SLEEP_GATE_OFF, 32'h0000_0000, 1'b0);
    rd_chk(12'h200, 32'h0000_0000, 1'b1);
    $display("test reserved done");

    // Run values: only hibernation clocked
    wr_reg(INT_EN_OFF, 32'h0000_0001);
    uacc(3'h0, 1'b1, 1'b1);
    rd_chk(INT_STAT_OFF, 32'h0000_0001, 1'b0);
    wr_reg(INT_STAT_OFF, 32'h0000_0000);
    rd_chk(INT_STAT_OFF, 32'h0000_0001, 1'b0);
    wr_reg(INT_CLR_OFF, 32'h0000_0001);
    #1;
    `CHK(irq, 1'b0, "interrupt after clear")
    rd_chk(INT_CLR_OFF, 32'h0000_0000, 1'b0);
    uacc(3'h1, 1'b0, 1'b0);
    uacc(3'h5, 1'b1, 1'b0);
    wr_reg(INT_EN_OFF, 32'h0000_0000);
    uacc(3'h2, 1'b1, 1'b0);
    rd_chk(INT_STAT_OFF, 32'h0000_0004, 1'b0);
    wr_reg(INT_CLR_OFF, 32'h0000_0004);
    $display("test fault done");

    wr_reg(RUN_CLK_CFG_OFF, 32'h0800_0000);
    sleep_req <= 1'b1;
    settle();
    `CHK(mode, MODE_SLEEP, "sleep mode")
    for (int i = 0; i < NUM_UNITS; i++) begin
      wr_reg(SLEEP_GATE_OFF, 32'h0000_0001 << gate_pos[i]);
      settle();
      `CHK(clk_en, 5'b00001 << i, "one unit clocked")
      uacc(i[2:0], 1'b0, 1'b0);
      uacc(3'((i + 1) % NUM_UNITS), 1'b1, 1'b0);
    end
    for (int s = 0; s < 4; s++) begin
      wr_reg(SLEEP_GATE_OFF, 32'(s) << 8);
      settle();
      `CHK(adc_speed, 2'(s), "sample speed")
    end
    $display("test sleep done");

    deepsleep_req <= 1'b1;
    settle();
    `CHK(mode, MODE_DEEP, "deep sleep mode")
    `CHK(clk_en, 5'b00010, "deep sleep enables")
    wr_reg(DEEP_GATE_OFF, 32'h0300_0000);
    settle();
    `CHK(clk_en, 5'b11000, "deep sleep controller units")
    deepsleep_req <= 1'b0;
    wr_reg(RUN_CLK_CFG_OFF, 32'h0000_0000);
    settle();
    `CHK(mode, MODE_RUN, "no auto gating")
    `CHK(clk_en, 5'b00010, "run values kept in sleep")
    $display("test modes done");
    close_out();
  end
endmodule
